// File: hw/acc_pkg.sv
// constants for the audio serial port clock, role and slot configuration
// assumes byte-wide registers reached through a simple register port
package acc_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CHANNEL4_SLOT_FIELD = 8'h0e;
   localparam logic [7:0] ADDR_ROLE = 8'h13;
   localparam logic [7:0] ADDR_RATE = 8'h14;
   localparam logic [7:0] ADDR_SRC = 8'h16;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [5:0] RST_SLOT = 6'h03;
   localparam logic [7:0] RST_ROLE = 8'h02;
   localparam logic [7:0] RST_RATE = 8'h48;
   localparam logic [7:0] RST_SRC = 8'h10;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SLOT_HALF_BIT = 5;
   localparam int ROLE_MASTER_BIT = 7;
   localparam int ROLE_AUTO_OFF_BIT = 6;
   localparam int ROLE_PLL_DIS_BIT = 5;
   localparam int ROLE_GATE_BIT = 4;
   localparam int ROLE_FAMILY_BIT = 3;
   localparam int RATE_CODE_LSB = 4;
   localparam int SRC_ROOT_SEL_BIT = 7;
   localparam int SRC_FREQ_MODE_BIT = 6;
   localparam logic [7:0] SRC_WRITE_MASK = 8'hfa;
   localparam logic [3:0] RATE_CODE_MAX = 4'h8;
endpackage

// File: hw/acc_config.sv
// clock role, rate and channel 4 slot configuration of the serial port
// assumes a same-clock register port; nrst may arrive asynchronously
//
// Contract
// RULE1 - channel 4 sits in the slot held by a six-bit field reset to 3, upper half meaning right half.
// RULE2 - the two upper bits of the slot register read zero and software writes only zero there.
// RULE3 - role bit 0 makes bit clock and frame sync inputs, 1 makes the device drive both.
// RULE4 - automatic clock bit 0 derives dividers and PLL automatically, 1 needs custom settings.
// RULE5 - in automatic mode the PLL is used when the bypass bit is 0 and skipped when it is 1.
// RULE6 - in master mode the gate bit stops outgoing bit clock and frame sync, no effect in slave.
// RULE7 - in master mode rate family bit 0 picks the 48 kHz family and 1 the 44.1 kHz family.
// RULE8 - in master mode with frequency mode 0 the three-bit code reset 2 gives the reference clock.
// RULE9 - the four-bit rate code reset 4 picks the bus rate and is ignored in slave automatic mode.
// RULE10 - software never writes rate codes 9 to 15 since they are reserved.
// RULE11 - frequency mode 0 takes the reference from the code, 1 from a multiple of frame rate; the block selects either only in master mode.
// RULE12 - slave automatic mode without PLL roots on bit clock unless the source bit picks the reference.
// RULE13 - reset restores every default and a written value acts only once the write completes.
`timescale 1ns/1ns
module acc_config
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic [5:0] channel4_slot_field,
   output logic ch4_right_half,
   output logic [4:0] ch4_half_slot,
   output logic bclk_oe,
   output logic frame_sync_oe,
   output logic clock_gate_on,
   output logic auto_derive_on,
   output logic pll_on,
   output logic family_441,
   output logic ref_from_code,
   output logic ref_from_ratio,
   output logic [2:0] ref_code,
   output logic rate_code_used,
   output logic [3:0] rate_code,
   output logic rate_code_valid,
   output logic root_from_bclk,
   output logic root_from_ref
);
   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_sync_reg;

   // two stages so the release edge never lands near a clock edge
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   wire logic rst_n = rst_sync_reg;

   // ----------------------------------------------------------------
   // registers and derived controls
   // ----------------------------------------------------------------
   logic [5:0] slot_reg, slot_next;
   logic [7:0] role_reg, role_next;
   logic [7:0] rate_reg, rate_next;
   logic [7:0] src_reg, src_next;
   logic [7:0] rdata_next;
   logic rvalid_next;
   logic [24:0] ctl_reg, ctl_next;
   logic m_n, auto_n, pdis_n, mode_n, rsel_n;

   // writes land on the edge, controls follow from the new values
   always_comb
   begin
      slot_next = slot_reg;
      role_next = role_reg;
      rate_next = rate_reg;
      src_next = src_reg;
      if (reg_wr)
      begin
         case (reg_addr)
            acc_pkg::ADDR_CHANNEL4_SLOT_FIELD: slot_next = reg_wdata[5:0]; // RULE2
            acc_pkg::ADDR_ROLE: role_next = reg_wdata;
            acc_pkg::ADDR_RATE: rate_next = reg_wdata;
            acc_pkg::ADDR_SRC:
               src_next = reg_wdata & acc_pkg::SRC_WRITE_MASK;
            default: ;
         endcase
      end
      // unmapped reads answer zero
      rvalid_next = reg_rd;
      rdata_next = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            acc_pkg::ADDR_CHANNEL4_SLOT_FIELD: rdata_next = {2'b00, slot_reg}; // RULE2
            acc_pkg::ADDR_ROLE: rdata_next = role_reg;
            acc_pkg::ADDR_RATE: rdata_next = rate_reg;
            acc_pkg::ADDR_SRC: rdata_next = src_reg;
            default: rdata_next = 8'h00;
         endcase
      end
      m_n = role_next[acc_pkg::ROLE_MASTER_BIT];
      auto_n = ~role_next[acc_pkg::ROLE_AUTO_OFF_BIT]; // RULE4
      pdis_n = role_next[acc_pkg::ROLE_PLL_DIS_BIT];
      mode_n = src_next[acc_pkg::SRC_FREQ_MODE_BIT];
      rsel_n = src_next[acc_pkg::SRC_ROOT_SEL_BIT];
      ctl_next[5:0] = slot_next; // RULE1
      ctl_next[6] = slot_next[acc_pkg::SLOT_HALF_BIT]; // RULE1
      ctl_next[7] = m_n; // RULE3
      ctl_next[8] = m_n & role_next[acc_pkg::ROLE_GATE_BIT]; // RULE6
      ctl_next[9] = auto_n; // RULE4
      ctl_next[10] = auto_n & ~pdis_n; // RULE5
      ctl_next[11] = m_n & role_next[acc_pkg::ROLE_FAMILY_BIT]; // RULE7
      ctl_next[12] = m_n & ~mode_n; // RULE8 RULE11
      ctl_next[13] = m_n & mode_n; // RULE11
      ctl_next[16:14] = role_next[2:0]; // RULE8
      ctl_next[17] = m_n | ~auto_n; // RULE9
      ctl_next[21:18] = rate_next[7:4]; // RULE9
      // reserved codes are flagged, not trusted
      ctl_next[22] = rate_next[7:4] <= acc_pkg::RATE_CODE_MAX; // RULE10
      ctl_next[23] = ~m_n & auto_n & pdis_n & ~rsel_n; // RULE12
      ctl_next[24] = ~m_n & auto_n & pdis_n & rsel_n; // RULE12
   end

   // reset values match the register defaults so controls agree at once
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot_reg <= acc_pkg::RST_SLOT; // RULE13
         role_reg <= acc_pkg::RST_ROLE; // RULE13
         rate_reg <= acc_pkg::RST_RATE; // RULE13
         src_reg <= acc_pkg::RST_SRC; // RULE13
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
         ctl_reg <= 25'h050_8603; // RULE4 RULE5 RULE9 RULE13
      end
      else if (ce)
      begin
         slot_reg <= slot_next;
         role_reg <= role_next;
         rate_reg <= rate_next;
         src_reg <= src_next;
         reg_rdata <= rdata_next;
         reg_rvalid <= rvalid_next;
         ctl_reg <= ctl_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign channel4_slot_field = ctl_reg[5:0];
   assign ch4_right_half = ctl_reg[6];
   assign ch4_half_slot = ctl_reg[4:0];
   assign bclk_oe = ctl_reg[7];
   assign frame_sync_oe = ctl_reg[7];
   assign clock_gate_on = ctl_reg[8];
   assign auto_derive_on = ctl_reg[9];
   assign pll_on = ctl_reg[10];
   assign family_441 = ctl_reg[11];
   assign ref_from_code = ctl_reg[12];
   assign ref_from_ratio = ctl_reg[13];
   assign ref_code = ctl_reg[16:14];
   assign rate_code_used = ctl_reg[17];
   assign rate_code = ctl_reg[21:18];
   assign rate_code_valid = ctl_reg[22];
   assign root_from_bclk = ctl_reg[23];
   assign root_from_ref = ctl_reg[24];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence slot_write_s;
      ce && reg_wr && reg_addr == acc_pkg::ADDR_CHANNEL4_SLOT_FIELD;
   endsequence

   sequence slot_read_s;
      ce && reg_rd && reg_addr == acc_pkg::ADDR_CHANNEL4_SLOT_FIELD;
   endsequence

   chk_slot_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
      slot_write_s |=> channel4_slot_field == $past(reg_wdata[5:0])) // RULE1 RULE13
      else $error("slot write not applied next cycle");
   chk_slot_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
      slot_read_s |=> reg_rvalid && reg_rdata[7:6] == 2'b00) // RULE2
      else $error("slot upper bits not zero");
   chk_right_half_bit: assert property (@(posedge clk) disable iff (!rst_n)
      ch4_right_half == (channel4_slot_field >= 6'd32)) // RULE1
      else $error("half flag disagrees with slot");
   chk_role_drives: assert property (@(posedge clk) disable iff (!rst_n)
      bclk_oe == role_reg[7] && frame_sync_oe == bclk_oe) // RULE3
      else $error("clock drive disagrees with role");
   chk_gate_master_only: assert property (@(posedge clk) disable iff (!rst_n)
      clock_gate_on |-> bclk_oe && role_reg[4]) // RULE6
      else $error("gate active outside master");
   chk_pll_auto_only: assert property (@(posedge clk) disable iff (!rst_n)
      pll_on |-> auto_derive_on && !role_reg[5]) // RULE4 RULE5
      else $error("pll used without automatic mode");
   chk_family_master: assert property (@(posedge clk) disable iff (!rst_n)
      family_441 |-> bclk_oe && role_reg[3]) // RULE7
      else $error("family select outside master");
   chk_ref_source_excl: assert property (@(posedge clk) disable iff (!rst_n)
      !(ref_from_code && ref_from_ratio)
      && ((ref_from_code || ref_from_ratio) == bclk_oe)) // RULE8 RULE11
      else $error("reference source selection wrong");
   chk_rate_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      (!bclk_oe && auto_derive_on) |-> !rate_code_used) // RULE9
      else $error("rate code used in slave auto mode");
   chk_root_select: assert property (@(posedge clk) disable iff (!rst_n)
      (root_from_bclk || root_from_ref) == (!bclk_oe && auto_derive_on
      && role_reg[5]) && !(root_from_bclk && root_from_ref)) // RULE12
      else $error("root clock selection wrong");
   chk_rate_valid_flag: assert property (@(posedge clk) disable iff (!rst_n)
      rate_code_valid == (rate_code < 4'd9)) // RULE10
      else $error("reserved rate flag wrong");
   chk_reset_default: assert property (@(posedge clk)
      $rose(rst_n) |-> channel4_slot_field == 6'd3 && ref_code == 3'd2
      && rate_code == 4'd4) // RULE13
      else $error("defaults not restored at reset");
endmodule // acc_config

// File: verification/acc_bus_host.sv
// model of the bus host that faces the serial port clock pins
// assumes the role output of the configuration block as its input
`timescale 1ns/1ns
module acc_bus_host
(
   input wire logic clk,
   input wire logic dev_drives,
   output logic host_drives,
   output logic bit_clk
);
   // host runs the bit clock only while it owns it; released it sits low
   always @(posedge clk)
   begin
      if (dev_drives)
         bit_clk <= 1'b0;
      else
         bit_clk <= (bit_clk === 1'b1) ? 1'b0 : 1'b1;
   end
   // host drives only while the device is a slave
   assign host_drives = ~dev_drives;
endmodule // acc_bus_host

// File: verification/tb_acc_config.sv
// self-checking bench for the slot and clock role configuration block
// assumes strobes taken at a rising edge and read data one cycle later
`timescale 1ns/1ns
module tb_acc_config;
   logic clk, nrst, ce, reg_wr, reg_rd, reg_rvalid, host_drives;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
   logic [5:0] channel4_slot_field;
   logic [4:0] ch4_half_slot;
   logic [2:0] ref_code;
   logic [3:0] rate_code;
   logic bclk_oe, frame_sync_oe, clock_gate_on, auto_derive_on, pll_on;
   logic family_441, ref_from_code, ref_from_ratio, rate_code_used;
   logic rate_code_valid, root_from_bclk, root_from_ref, ch4_right_half;
   logic [11:0] flags;
   int bad_count = 0;
   int total_checks = 0;
   // rows: address, write data, read back, flags after the write
   logic [7:0] ra [9] = '{8'h0e, 8'h0e, 8'h13, 8'h16, 8'h13, 8'h13,
      8'h16, 8'h14, 8'h10};
   logic [7:0] rw [9] = '{8'h3f, 8'h25, 8'h9f, 8'hf8, 8'h70, 8'h20,
      8'h00, 8'h80, 8'haa};
   logic [7:0] rr [9] = '{8'h3f, 8'h25, 8'h9f, 8'hf8, 8'h70, 8'h20,
      8'h00, 8'h80, 8'h00};
   logic [11:0] rf [9] = '{12'h181, 12'h181, 12'hfe9, 12'hfd9, 12'h009,
      12'h103, 12'h105, 12'h105, 12'h105};
   assign flags = {bclk_oe, frame_sync_oe, clock_gate_on, auto_derive_on,
      pll_on, family_441, ref_from_code, ref_from_ratio, rate_code_used,
      root_from_bclk, root_from_ref, rate_code_valid};
   acc_config u_dut (.clk(clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .channel4_slot_field(channel4_slot_field),
      .ch4_right_half(ch4_right_half), .ch4_half_slot(ch4_half_slot),
      .bclk_oe(bclk_oe), .frame_sync_oe(frame_sync_oe),
      .clock_gate_on(clock_gate_on), .auto_derive_on(auto_derive_on),
      .pll_on(pll_on), .family_441(family_441),
      .ref_from_code(ref_from_code), .ref_from_ratio(ref_from_ratio),
      .ref_code(ref_code), .rate_code_used(rate_code_used),
      .rate_code(rate_code), .rate_code_valid(rate_code_valid),
      .root_from_bclk(root_from_bclk), .root_from_ref(root_from_ref));
   acc_bus_host u_host (.clk(clk), .dev_drives(bclk_oe),
      .host_drives(host_drives), .bit_clk());
   // 50 ns clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   // answer is settled by the falling edge after the taking edge
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      q = reg_rdata;
      chk(12'(reg_rvalid), 12'h001);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      nrst = 1'b0;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (16) @(negedge clk);
      chk(flags, 12'h181);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      chk(flags, 12'h181);
      chk(12'(channel4_slot_field), 12'h003);
      chk(12'(ref_code), 12'h002);
      chk(12'(rate_code), 12'h004);
      chk(12'(host_drives), 12'h001);
      rd(8'h13);
      chk(12'(q), 12'h002);
      rd(8'h14);
      chk(12'(q), 12'h048);
      $display("test reset done");
      // reserved rate codes are never written
      for (int i = 0; i < 9; i++)
      begin
         wr(ra[i], rw[i]);
         chk(flags, rf[i]);
         rd(ra[i]);
         chk(12'(q), 12'(rr[i]));
      end
      $display("test rows done");
      chk(12'({ch4_right_half, ch4_half_slot}), 12'h025);
      chk(12'(rate_code), 12'h008);
      wr(8'h13, 8'h85);
      chk(12'({ref_code, family_441, clock_gate_on}), 12'h014);
      chk(12'(host_drives), 12'h000);
      wr(8'h14, 8'h00);
      chk(12'({rate_code, rate_code_valid}), 12'h001);
      // frozen port must ignore the strobe
      ce = 1'b0;
      wr(8'h0e, 8'h11);
      ce = 1'b1;
      rd(8'h0e);
      chk(12'(q), 12'h025);
      $display("test edge cases done");
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      chk(flags, 12'h181);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      chk(flags, 12'h181);
      rd(8'h0e);
      chk(12'(q), 12'h003);
      $display("test second reset done");
      conclude();
   end
   // cuts a hang short
   initial
   begin
      #2000000;
      bad_count++;
      $display("[FAIL] %0t run limit reached", $time);
      conclude();
   end
endmodule // tb_acc_config
